// ==== pemm_pkg.sv ====
// constants and types for the protected multiframe mapper
// Operation
// [R1] multiframe is 192 frames, 6144 timeslots
// [R2] three superblocks, eight blocks, eight frames
// [R3] frame is 32 byte timeslots, 125 us
// [R4] timeslots 0 and 16 carry line bytes
// [R5] frame 0 ts1 management, ts2 supervision
// [R6] management b0..b2 carry block index
// [R7] management b3..b4 carry superblock index
// [R8] b5 bits form 24-bit timestamp word
// [R9] b6 bits form 24-bit signalling word
// [R10] first signalling bit flags CRC violations
// [R11] second signalling bit flags variant
// [R12] superblock 1 signalling bits carry error field
// [R13] receiver ignores those bits when size zero
// [R14] receiver aligns on counters, not sync byte
// [R15] high capacity carries 5592 transport bytes
// [R16] high protection carries 5376 transport bytes
// [R17] high capacity frame length is 5596
// [R18] high protection frame length is 5380
// [R19] transport sync field is never sent
// [R20] receiver may rewrite error field
// [R21] supervision bytes form three eight-byte groups
// [R22] reserved bits sent as zero
// [R23] each timeslot sent b0 first, MSB
package pemm_pkg;
    localparam int          MF_TIME_MS      = 24;
    localparam int          FRAME_TIME_US   = 125;
    localparam int          FRAMES_PER_MF   = 192;
    localparam logic [12:0] SLOTS_LAST      = 13'h17FF;
    localparam logic [4:0]  TS_SYNC         = 5'h00;
    localparam logic [4:0]  TS_LINE_SIG     = 5'h10;
    localparam logic [4:0]  TS_MGMT         = 5'h01;
    localparam logic [4:0]  TS_SUPER        = 5'h02;
    localparam logic [12:0] CAP_CAPACITY    = 13'h15D8;
    localparam logic [12:0] CAP_PROTECT     = 13'h1500;
    localparam logic [12:0] TFL_CAPACITY    = 13'h15DC;
    localparam logic [12:0] TFL_PROTECT     = 13'h1504;
    localparam logic [4:0]  SIG_CRC_POS     = 5'h00;
    localparam logic [4:0]  SIG_VAR_POS     = 5'h01;
    localparam logic [4:0]  SIG_ERR_FIRST   = 5'h08;
    localparam logic [4:0]  SIG_ERR_LAST    = 5'h0F;
    localparam logic [3:0]  ADDR_CTRL       = 4'h0;
    localparam logic [3:0]  ADDR_STATUS     = 4'h4;
    localparam logic [3:0]  ADDR_COUNT      = 4'h8;
    localparam logic [1:0]  CTRL_RESET      = 2'h0;
    typedef enum logic [0:0] {
        PEMM_IDLE = 1'b0,
        PEMM_RUN  = 1'b1
    } pemm_state_t;
    typedef enum logic [1:0] {
        PEMM_K_LINE = 2'b00,
        PEMM_K_MGMT = 2'b01,
        PEMM_K_SUP  = 2'b10,
        PEMM_K_PAY  = 2'b11
    } pemm_kind_t;
endpackage

// ==== pemm_mapper.sv ====
// multiframe mapper: serialises 24 ms multiframes onto the 2048 kbit/s line
//
// Chosen here: the register offsets and the plain strobed port.
module pemm_mapper (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        clkEn,
    input  wire logic        lineBitEn,
    output logic             lineData,
    output logic             mfStart,
    input  wire logic [7:0]  lineSyncByte,
    input  wire logic [7:0]  lineSigByte,
    input  wire logic [7:0]  payloadByte,
    input  wire logic        payloadValid,
    output logic             payloadReady,
    input  wire logic [7:0]  supervisionByte,
    output logic             supervisionTake,
    input  wire logic [23:0] timestampWord,
    input  wire logic        crcViolation,
    input  wire logic [7:0]  errorField,
    input  wire logic        dataFieldSizeZero,
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [31:0]      regRdData
);
    typedef struct packed {
        pemm_pkg::pemm_state_t state;
        logic [12:0]           slot;
        logic [2:0]            bitIdx;
        logic [7:0]            shift;
        logic [12:0]           payCount;
        logic [23:0]           stamp;
        logic [23:0]           sigWord;
        logic                  enable;
        logic                  variant;
        logic                  underrun;
        logic [15:0]           mfCount;
        logic [31:0]           rdData;
    } pemm_regs_t;

    pemm_regs_t r_reg;
    pemm_regs_t r_next;

    function automatic pemm_pkg::pemm_kind_t slotKind(input logic [12:0] s);
        // line bytes win; management/supervision only in frame 0 of each block
        if (s[4:0] == pemm_pkg::TS_SYNC || s[4:0] == pemm_pkg::TS_LINE_SIG)
            return pemm_pkg::PEMM_K_LINE; // R4
        if (s[7:5] == 3'h0 && s[4:0] == pemm_pkg::TS_MGMT)
            return pemm_pkg::PEMM_K_MGMT; // R5
        if (s[7:5] == 3'h0 && s[4:0] == pemm_pkg::TS_SUPER)
            return pemm_pkg::PEMM_K_SUP; // R5
        return pemm_pkg::PEMM_K_PAY;
    endfunction

    function automatic logic [23:0] buildSig(input logic crc, input logic var_, input logic [7:0] err,
                                             input logic dfsZero);
        logic [23:0] w;
        w = 24'h000000; // R22
        // word bit 23 rides in block 0 of superblock 0
        w[23] = crc & ~dfsZero; // R10 R13
        w[22] = var_; // R11
        for (int i = 0; i < 8; i++) begin
            w[15 - i] = err[7 - i] & ~dfsZero; // R12 R20
        end
        return w;
    endfunction

    logic [4:0]  blockSeq;
    logic [7:0]  mgmtByte;
    logic        loadNow;
    logic [12:0] capacity;
    pemm_pkg::pemm_kind_t kindNow;

    always_comb begin
        kindNow  = slotKind(r_reg.slot);
        blockSeq = {r_reg.slot[12:11], 3'h0} + {2'h0, r_reg.slot[10:8]};
        capacity = r_reg.variant ? pemm_pkg::CAP_PROTECT : pemm_pkg::CAP_CAPACITY; // R15 R16 R17 R18
        // b0 is the byte MSB
        mgmtByte = {r_reg.slot[10:8], r_reg.slot[12:11], // R6 R7 R14
                    r_reg.stamp[5'd23 - blockSeq], // R8
                    r_reg.sigWord[5'd23 - blockSeq], // R9
                    1'b0}; // R22
        loadNow  = r_reg.state == pemm_pkg::PEMM_RUN && lineBitEn && r_reg.bitIdx == 3'h0;
    end

    // payload bytes beyond the transport count stand in for parity
    assign payloadReady    = clkEn && loadNow && kindNow == pemm_pkg::PEMM_K_PAY &&
                             r_reg.payCount < capacity;
    assign supervisionTake = clkEn && loadNow && kindNow == pemm_pkg::PEMM_K_SUP; // R21
    assign lineData        = r_reg.shift[7]; // R23
    assign mfStart         = r_reg.state == pemm_pkg::PEMM_RUN && r_reg.slot == 13'h0000 &&
                             r_reg.bitIdx == 3'h0;
    assign regRdData       = r_reg.rdData;

    always_comb begin
        r_next = r_reg;
        r_next.rdData = 32'h00000000;
        if (regWr && regAddr == pemm_pkg::ADDR_CTRL) begin
            r_next.enable  = regWrData[0];
            r_next.variant = regWrData[1];
        end
        if (regRd) begin
            case (regAddr)
                pemm_pkg::ADDR_CTRL:   r_next.rdData = {30'h0, r_reg.variant, r_reg.enable};
                pemm_pkg::ADDR_STATUS: r_next.rdData = {15'h0, r_reg.underrun, r_reg.bitIdx,
                                                        r_reg.slot};
                pemm_pkg::ADDR_COUNT:  r_next.rdData = {16'h0, r_reg.mfCount};
                default:               r_next.rdData = 32'h00000000;
            endcase
        end
        if (regRd && regAddr == pemm_pkg::ADDR_STATUS)
            r_next.underrun = 1'b0;
        case (r_reg.state)
            pemm_pkg::PEMM_IDLE: begin
                r_next.shift = 8'h00;
                if (r_reg.enable) begin
                    // variant enters the signalling word here and at each wrap; capacity follows it at once
                    r_next.state    = pemm_pkg::PEMM_RUN;
                    r_next.slot     = 13'h0000;
                    r_next.bitIdx   = 3'h0;
                    r_next.payCount = 13'h0000;
                    r_next.stamp    = timestampWord;
                    r_next.sigWord  = buildSig(crcViolation, r_reg.variant, errorField,
                                               dataFieldSizeZero);
                end
            end
            pemm_pkg::PEMM_RUN: begin
                if (lineBitEn) begin
                    r_next.bitIdx = r_reg.bitIdx + 3'h1; // R3
                    if (r_reg.bitIdx == 3'h0) begin
                        case (kindNow)
                            pemm_pkg::PEMM_K_LINE:
                                r_next.shift = r_reg.slot[4] ? lineSigByte : lineSyncByte; // R4
                            pemm_pkg::PEMM_K_MGMT:
                                r_next.shift = mgmtByte; // R5
                            pemm_pkg::PEMM_K_SUP:
                                r_next.shift = supervisionByte; // R21
                            pemm_pkg::PEMM_K_PAY: begin
                                if (r_reg.payCount < capacity) begin
                                    r_next.shift    = payloadValid ? payloadByte : 8'h00; // R19
                                    r_next.payCount = r_reg.payCount + 13'h0001;
                                    if (!payloadValid)
                                        r_next.underrun = 1'b1;
                                end else begin
                                    r_next.shift = 8'h00; // R15 R16
                                end
                            end
                            default: r_next.shift = 8'h00;
                        endcase
                    end else begin
                        r_next.shift = {r_reg.shift[6:0], 1'b0}; // R23
                    end
                    if (r_reg.bitIdx == 3'h7) begin
                        if (r_reg.slot == pemm_pkg::SLOTS_LAST) begin // R1 R2
                            r_next.slot    = 13'h0000;
                            r_next.mfCount = r_reg.mfCount + 16'h0001;
                            r_next.payCount = 13'h0000;
                            if (!r_reg.enable)
                                r_next.state = pemm_pkg::PEMM_IDLE;
                            r_next.stamp   = timestampWord;
                            r_next.sigWord = buildSig(crcViolation, r_reg.variant, errorField,
                                                      dataFieldSizeZero);
                        end else begin
                            r_next.slot = r_reg.slot + 13'h0001;
                        end
                    end
                end
            end
            default: r_next.state = pemm_pkg::PEMM_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg          <= '0;
            r_reg.state    <= pemm_pkg::PEMM_IDLE;
            r_reg.enable   <= pemm_pkg::CTRL_RESET[0];
            r_reg.variant  <= pemm_pkg::CTRL_RESET[1];
        end else if (clkEn) begin
            r_reg <= r_next;
        end
    end

    // checks
    a_slot_bound: assert property (@(posedge clk) disable iff (!resetn) // R1
        r_reg.slot <= pemm_pkg::SLOTS_LAST) else $error("slot beyond multiframe");
    a_mgmt_pos: assert property (@(posedge clk) disable iff (!resetn) // R5
        slotKind(r_reg.slot) == pemm_pkg::PEMM_K_MGMT |-> r_reg.slot[7:0] == 8'h01)
        else $error("management byte misplaced");
    a_line_nopay: assert property (@(posedge clk) disable iff (!resetn) // R4
        payloadReady |-> r_reg.slot[3:0] != 4'h0) else $error("payload in line slot");
    a_cap_limit: assert property (@(posedge clk) disable iff (!resetn) // R15
        r_reg.payCount <= (r_reg.variant ? pemm_pkg::CAP_PROTECT : pemm_pkg::CAP_CAPACITY))
        else $error("payload count over capacity");
    a_mgmt_index: assert property (@(posedge clk) disable iff (!resetn) // R6
        clkEn && loadNow && kindNow == pemm_pkg::PEMM_K_MGMT |=> r_reg.shift[7:5] == $past(r_reg.slot[10:8]))
        else $error("block index wrong");
    a_sb_index: assert property (@(posedge clk) disable iff (!resetn) // R7
        clkEn && loadNow && kindNow == pemm_pkg::PEMM_K_MGMT |=> r_reg.shift[4:3] == $past(r_reg.slot[12:11]))
        else $error("superblock index wrong");
    a_rsv_zero: assert property (@(posedge clk) disable iff (!resetn) // R22
        clkEn && loadNow && kindNow == pemm_pkg::PEMM_K_MGMT |=> r_reg.shift[0] == 1'b0)
        else $error("reserved bit set");
    a_var_bit: assert property (@(posedge clk) disable iff (!resetn) // R11
        r_reg.state == pemm_pkg::PEMM_RUN |-> r_reg.sigWord[22] == r_reg.variant)
        else $error("variant bit wrong");
    a_shift_msb: assert property (@(posedge clk) disable iff (!resetn) // R23
        clkEn && lineBitEn && r_reg.state == pemm_pkg::PEMM_RUN && r_reg.bitIdx != 3'h0
        |=> lineData == $past(r_reg.shift[6])) else $error("bit order wrong");

    // helper terms for the checks below
    logic stepNow;
    logic wrapNow;
    logic loadEn;
    assign stepNow = clkEn && lineBitEn && r_reg.state == pemm_pkg::PEMM_RUN;
    assign wrapNow = stepNow && r_reg.bitIdx == 3'h7 && r_reg.slot == pemm_pkg::SLOTS_LAST;
    assign loadEn  = clkEn && loadNow;

    // counters and framing
    a_bit_step: assert property (@(posedge clk) disable iff (!resetn) // R3
        stepNow |=> r_reg.bitIdx == $past(r_reg.bitIdx) + 3'h1)
        else $error("bit counter skipped");

    a_slot_step: assert property (@(posedge clk) disable iff (!resetn) // R2
        stepNow && r_reg.bitIdx == 3'h7 && r_reg.slot != pemm_pkg::SLOTS_LAST
        |=> r_reg.slot == $past(r_reg.slot) + 13'h0001) else $error("slot counter skipped");

    a_mf_wrap: assert property (@(posedge clk) disable iff (!resetn) // R1
        wrapNow |=> r_reg.slot == 13'h0000 && r_reg.mfCount == $past(r_reg.mfCount) + 16'h0001)
        else $error("multiframe wrap wrong");

    a_pay_restart: assert property (@(posedge clk) disable iff (!resetn) // R15
        wrapNow |=> r_reg.payCount == 13'h0000)
        else $error("payload count not restarted");

    a_stop_idle: assert property (@(posedge clk) disable iff (!resetn)
        wrapNow && !r_reg.enable |=> r_reg.state == pemm_pkg::PEMM_IDLE)
        else $error("no stop at multiframe end");

    a_run_start: assert property (@(posedge clk) disable iff (!resetn)
        clkEn && r_reg.state == pemm_pkg::PEMM_IDLE && r_reg.enable
        |=> r_reg.state == pemm_pkg::PEMM_RUN && r_reg.slot == 13'h0000 && r_reg.bitIdx == 3'h0)
        else $error("run start wrong");

    // words sampled at multiframe start
    a_stamp_take: assert property (@(posedge clk) disable iff (!resetn) // R8
        wrapNow |=> r_reg.stamp == $past(timestampWord))
        else $error("timestamp not taken");

    a_crc_take: assert property (@(posedge clk) disable iff (!resetn) // R10
        wrapNow |=> r_reg.sigWord[23] == ($past(crcViolation) && !$past(dataFieldSizeZero)))
        else $error("crc flag wrong");

    a_err_take: assert property (@(posedge clk) disable iff (!resetn) // R12
        wrapNow |=> r_reg.sigWord[15:8] == ($past(dataFieldSizeZero) ? 8'h00 : $past(errorField)))
        else $error("error field wrong");

    a_rsv_sig: assert property (@(posedge clk) disable iff (!resetn) // R22
        r_reg.state == pemm_pkg::PEMM_RUN |-> r_reg.sigWord[21:16] == 6'h00 && r_reg.sigWord[7:0] == 8'h00)
        else $error("reserved signalling bit set");

    // byte loads per slot kind
    a_sync_load: assert property (@(posedge clk) disable iff (!resetn) // R4
        loadEn && kindNow == pemm_pkg::PEMM_K_LINE && !r_reg.slot[4] |=> r_reg.shift == $past(lineSyncByte))
        else $error("sync byte wrong");

    a_sig_load: assert property (@(posedge clk) disable iff (!resetn) // R4
        loadEn && kindNow == pemm_pkg::PEMM_K_LINE && r_reg.slot[4] |=> r_reg.shift == $past(lineSigByte))
        else $error("line signalling byte wrong");

    a_sup_pos: assert property (@(posedge clk) disable iff (!resetn) // R5
        supervisionTake |-> r_reg.slot[7:0] == 8'h02)
        else $error("supervision byte misplaced");

    a_sup_load: assert property (@(posedge clk) disable iff (!resetn) // R21
        supervisionTake |=> r_reg.shift == $past(supervisionByte))
        else $error("supervision byte wrong");

    a_stamp_bit: assert property (@(posedge clk) disable iff (!resetn) // R8
        loadEn && kindNow == pemm_pkg::PEMM_K_MGMT |=> r_reg.shift[2] == $past(r_reg.stamp[5'd23 - blockSeq]))
        else $error("timestamp bit wrong");

    a_sig_bit: assert property (@(posedge clk) disable iff (!resetn) // R9
        loadEn && kindNow == pemm_pkg::PEMM_K_MGMT |=> r_reg.shift[1] == $past(r_reg.sigWord[5'd23 - blockSeq]))
        else $error("signalling bit wrong");

    a_pay_slot: assert property (@(posedge clk) disable iff (!resetn) // R4
        payloadReady |-> r_reg.slot[4:0] != pemm_pkg::TS_SYNC && r_reg.slot[4:0] != pemm_pkg::TS_LINE_SIG)
        else $error("payload taken in reserved slot");

    a_pay_load: assert property (@(posedge clk) disable iff (!resetn) // R19
        payloadReady && payloadValid |=> r_reg.shift == $past(payloadByte))
        else $error("payload byte wrong");

    a_pay_under: assert property (@(posedge clk) disable iff (!resetn)
        payloadReady && !payloadValid |=> r_reg.shift == 8'h00 && r_reg.underrun)
        else $error("underrun not flagged");

    a_parity_zero: assert property (@(posedge clk) disable iff (!resetn) // R16
        loadEn && kindNow == pemm_pkg::PEMM_K_PAY && !payloadReady |=> r_reg.shift == 8'h00)
        else $error("parity area not zero");

    // enables and quiet states
    a_clk_freeze: assert property (@(posedge clk) disable iff (!resetn)
        !clkEn |=> r_reg == $past(r_reg))
        else $error("state moved while frozen");

    a_idle_quiet: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.state == pemm_pkg::PEMM_IDLE |-> !payloadReady && !supervisionTake && !mfStart)
        else $error("activity while idle");

    a_line_hold: assert property (@(posedge clk) disable iff (!resetn) // R23
        !lineBitEn && r_reg.state == pemm_pkg::PEMM_RUN |=> $stable(lineData))
        else $error("line bit moved between enables");

    // register port
    a_ctrl_wr: assert property (@(posedge clk) disable iff (!resetn)
        clkEn && regWr && regAddr == pemm_pkg::ADDR_CTRL
        |=> r_reg.enable == $past(regWrData[0]) && r_reg.variant == $past(regWrData[1]))
        else $error("control write lost");

    a_rd_idle: assert property (@(posedge clk) disable iff (!resetn)
        clkEn && !regRd |=> regRdData == 32'h00000000)
        else $error("read data outside read cycle");

    a_count_rd: assert property (@(posedge clk) disable iff (!resetn)
        clkEn && regRd && regAddr == pemm_pkg::ADDR_COUNT |=> regRdData == {16'h0000, $past(r_reg.mfCount)})
        else $error("count read wrong");

    c_size_zero: cover property (@(posedge clk) disable iff (!resetn) wrapNow && dataFieldSizeZero);
    c_clk_hold: cover property (@(posedge clk) disable iff (!resetn) !clkEn && r_reg.state == pemm_pkg::PEMM_RUN);
    c_mf_wrap: cover property (@(posedge clk) disable iff (!resetn)
        r_reg.slot == pemm_pkg::SLOTS_LAST && r_reg.bitIdx == 3'h7 && lineBitEn && clkEn);
    c_sup_take: cover property (@(posedge clk) disable iff (!resetn) supervisionTake);
    c_underrun: cover property (@(posedge clk) disable iff (!resetn) r_reg.underrun);
endmodule // pemm_mapper

// ==== pemm_line_sink.sv ====
// line-side receiver model: deserialises multiframes from the serial line
module pemm_line_sink (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic lineBitEn,
    input  wire logic lineData,
    input  wire logic mfStart,
    output logic [7:0] rxMf [6144],
    output int         mfDone,
    output logic       armed
);
    timeunit 1ns;
    timeprecision 1ps;
    int         cnt;
    logic [7:0] sh;
    // a bit launched at one enable is taken at the next one
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt = 0;
            armed = 1'b0;
            mfDone = 0;
            sh = 8'h00;
        end else if (lineBitEn) begin
            if (armed) begin
                sh = {sh[6:0], lineData};
                if (cnt % 8 == 7) rxMf[cnt / 8] = sh;
                cnt++;
                if (cnt == 49152) mfDone++;
            end
            if (mfStart) begin
                cnt = 0;
                armed = 1'b1;
            end
        end
    end
endmodule // pemm_line_sink

// ==== tb_top.sv ====
// self-checking bench for the multiframe mapper
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, resetn, clkEn, lineBitEn, payloadValid, crcViolation, dataFieldSizeZero, regWr, regRd;
    logic        lineData, mfStart, payloadReady, supervisionTake, armed, variant;
    logic [7:0]  lineSyncByte, lineSigByte, payloadByte, supervisionByte, errorField;
    logic [23:0] timestampWord;
    logic [3:0]  regAddr;
    logic [31:0] regWrData, regRdData, rd;
    logic [7:0]  rxMf [6144];
    logic [7:0]  payQ [$], supQ [$];
    logic [23:0] stampE [2];
    logic [7:0]  errE [2];
    logic        crcE [2], dzE [2];
    int          mfDone, mismatches, checksDone, cyc;

    pemm_mapper i_pemm_mapper (.clk(clk), .resetn(resetn), .clkEn(clkEn), .lineBitEn(lineBitEn),
        .lineData(lineData), .mfStart(mfStart), .lineSyncByte(lineSyncByte), .lineSigByte(lineSigByte),
        .payloadByte(payloadByte), .payloadValid(payloadValid), .payloadReady(payloadReady),
        .supervisionByte(supervisionByte), .supervisionTake(supervisionTake), .timestampWord(timestampWord),
        .crcViolation(crcViolation), .errorField(errorField), .dataFieldSizeZero(dataFieldSizeZero),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
    pemm_line_sink i_pemm_line_sink (.clk(clk), .resetn(resetn), .lineBitEn(lineBitEn), .lineData(lineData),
        .mfStart(mfStart), .rxMf(rxMf), .mfDone(mfDone), .armed(armed));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask
    // walks one captured multiframe slot by slot
    task automatic check_mf(input int m);
        int   fr, ts, ix, pn, cap, tk;
        logic sg;
        cap = variant ? int'(pemm_pkg::CAP_PROTECT) : int'(pemm_pkg::CAP_CAPACITY);
        pn = 0;
        tk = 0;
        for (int q = 0; q < 6144; q++) begin
            fr = q / 32;
            ts = q % 32;
            ix = fr / 8;
            sg = (ix == 0) ? crcE[m] & !dzE[m] : (ix == 1) ? variant
                : (ix >= 8 && ix <= 15) ? errE[m][15 - ix] & !dzE[m] : 1'b0;
            if (ts == 0) check("sync slot", rxMf[q], lineSyncByte);
            else if (ts == 16) check("signal slot", rxMf[q], lineSigByte);
            else if (fr % 8 == 0 && ts == 1) check("mgmt byte", rxMf[q],
                {ix[2:0], ix[4:3], stampE[m][23 - ix], sg, 1'b0});
            else if (fr % 8 == 0 && ts == 2) check("supervision byte", rxMf[q], supQ.pop_front());
            else begin
                check("payload byte", rxMf[q], (pn < cap) ? payQ.pop_front() : 8'h00);
                if (pn < cap) tk++;
                pn++;
            end
        end
        check("payload slots", pn, 32'd5712);
        check("transport bytes", tk, (variant ? 32'd5380 : 32'd5596) - 32'd4);
        $display("test multiframe %0d done", m);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // payload and supervision sources, plus the hang limit
    always @(posedge clk) begin
        if (payloadReady === 1'b1) payQ.push_back(payloadValid ? payloadByte : 8'h00);
        if (supervisionTake === 1'b1) supQ.push_back(supervisionByte);
        payloadByte <= 8'($urandom);
        payloadValid <= ($urandom % 8) != 0;
        supervisionByte <= 8'($urandom);
        lineBitEn <= (cyc % 128) != 5 && (cyc % 128) != 70;
        clkEn <= !(armed === 1'b1 && mfDone < 2) || (cyc % 128) != 5;
        cyc++;
        if (cyc == 102000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        void'($urandom(32'hb09a1ee7));
        resetn = 1'b0;
        clkEn = 1'b1;
        lineBitEn = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 4'h0;
        regWrData = 32'h0;
        payloadByte = 8'h00;
        payloadValid = 1'b0;
        supervisionByte = 8'h00;
        variant = 1'($urandom);
        lineSyncByte = 8'($urandom);
        lineSigByte = 8'($urandom);
        stampE[0] = 24'($urandom);
        errE[0] = 8'($urandom);
        crcE[0] = 1'b1;
        dzE[0] = 1'b0;
        timestampWord = stampE[0];
        errorField = errE[0];
        crcViolation = crcE[0];
        dataFieldSizeZero = dzE[0];
        repeat (2) @(posedge clk);
        check("line idle at reset", lineData, 32'h0);
        check("start flag at reset", mfStart, 32'h0);
        resetn <= 1'b1;
        reg_wr(pemm_pkg::ADDR_CTRL, {30'h0, variant, 1'b1});
        reg_rd(4'hC, rd);
        check("unmapped read", rd, 32'h0);
        $display("test registers done");
        wait (armed === 1'b1);
        @(posedge clk);
        stampE[1] = 24'($urandom);
        errE[1] = 8'($urandom);
        crcE[1] = 1'b1;
        dzE[1] = 1'b1;
        timestampWord <= stampE[1];
        errorField <= errE[1];
        dataFieldSizeZero <= dzE[1];
        wait (mfDone == 1);
        check_mf(0);
        wait (mfDone == 2);
        check_mf(1);
        reg_rd(pemm_pkg::ADDR_CTRL, rd);
        check("control read", rd, {30'h0, variant, 1'b1});
        reg_rd(pemm_pkg::ADDR_COUNT, rd);
        check("multiframe count", rd, 32'd2);
        reg_rd(pemm_pkg::ADDR_STATUS, rd);
        check("underrun flag", rd[16], 32'h1);
        $display("test register readback done");
        give_verdict();
    end
endmodule // tb_top
